// file: hdl/lmsid_pkg.sv
// Constants for the LED multiplex scan, intensity and digit decode block.
// Assumes a 200 MHz core clock and a 16-bit address/data serial word.
package lmsid_pkg;

   localparam int CORE_CLK_HZ = 200_000_000;

   // Serial word layout: address in the high byte, data in the low byte.
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 8;
   localparam int DATA_MSB = 7;
   localparam int DATA_LSB = 0;

   // Register addresses.
   localparam logic [7:0] ADDR_DECODE_SELECT = 8'h01;
   localparam logic [7:0] ADDR_DUTY_LEVEL = 8'h02;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;

   // Configuration register fields.
   localparam int CFG_RATE_BIT = 2;
   localparam int CFG_BLINK_EN_BIT = 3;
   localparam int CFG_SYNC_BIT = 4;

   // Register reset values.
   localparam logic [7:0] DECODE_SELECT_RESET = 8'h00;
   localparam logic [7:0] DUTY_LEVEL_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;

   // Duty field: low nibble, code 15 behaves as code 14.
   localparam int DUTY_MSB = 3;
   localparam logic [3:0] DUTY_TOP_CODE = 4'hF;
   localparam logic [3:0] DUTY_MAX_STEP = 4'hE;
   localparam logic [3:0] DUTY_STEPS_LAST = 4'hF;

   // Scan timing at the reference multiplex clock.
   localparam int REF_MUX_HZ = 4_000_000;
   localparam int SLOT_TIME_US = 200;
   localparam int SLOT_TICKS = REF_MUX_HZ / 1_000_000 * SLOT_TIME_US;
   localparam int DUTY_STEPS = 16;
   localparam int SUB_TICKS = SLOT_TICKS / DUTY_STEPS;
   localparam int DIGITS_DEFAULT = 8;

   // Fast blink is 1 Hz at the reference clock; slow blink is half of it.
   localparam int FAST_BLINK_HZ = 1;
   localparam int FAST_HALF_TICKS = REF_MUX_HZ / (2 * FAST_BLINK_HZ);

   // Fail-safe: except across a sync write, which restarts its count, the effective multiplex clock never drops below 75.5 kHz.
   localparam int FS_MIN_FREQ_HZ = 75_500;
   localparam int FS_LIMIT_CYCLES = CORE_CLK_HZ / FS_MIN_FREQ_HZ;

   // Segment order in a decoded byte: dp, a, b, c, d, e, f, g.
   localparam int DP_BIT = 7;
   localparam logic [6:0] LMSID_FONT [16] = '{
      7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70,
      7'h7F, 7'h7B, 7'h77, 7'h1F, 7'h4E, 7'h3F, 7'h4F, 7'h47};

endpackage

// file: hdl/lmsid_hex_font.sv
// Hexadecimal segment font with decimal point, or raw segment pass-through.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module lmsid_hex_font
   import lmsid_pkg::*;
(
   input wire logic [7:0] i_data,
   input wire logic i_decode,
   output logic [7:0] o_segments
);

   wire [6:0] font_bits;

   // Bits 6 to 4 play no part in the lookup.
   assign font_bits = LMSID_FONT[i_data[3:0]];

   // The decimal point follows bit 7 in both modes.
   assign o_segments = i_decode ? {i_data[DP_BIT], font_bits}
                                : i_data;

endmodule // lmsid_hex_font

// file: hdl/lmsid_scan.sv
// Multiplex scan timing, blink timing, segment duty and digit decode.
// Assumes serial pins and the multiplex clock pin are synchronous to I_CORE_CLK,
// and that digit data for O_SCAN_DIGIT arrives combinationally on I_DIGIT_DATA.
`timescale 1ns/1ps

module lmsid_scan
   import lmsid_pkg::*;
#(
   parameter int NUM_DIGITS = DIGITS_DEFAULT,
   parameter int BLINK_HALF_TICKS = FAST_HALF_TICKS
)
(
   input wire logic I_CORE_CLK,
   input wire logic I_RESET,
   input wire logic I_CS_N,
   input wire logic I_SCLK,
   input wire logic I_DIN,
   input wire logic I_MUX_CLOCK_PIN,
   input wire logic [7:0] I_DIGIT_DATA,
   output logic [$clog2(NUM_DIGITS)-1:0] O_SCAN_DIGIT,
   output logic [NUM_DIGITS-1:0] O_DIGIT_ENABLE,
   output logic [7:0] O_SEGMENT,
   output logic O_BLINK_PHASE,
   output logic O_FAILSAFE_ACTIVE
);

   localparam int DIGIT_W = $clog2(NUM_DIGITS);
   localparam int HALF_W = $clog2(BLINK_HALF_TICKS);
   localparam int SUB_W = $clog2(SUB_TICKS);
   localparam int FS_W = $clog2(FS_LIMIT_CYCLES + 1);
   localparam logic [DIGIT_W-1:0] LAST_DIGIT = DIGIT_W'(NUM_DIGITS - 1);
   localparam logic [SUB_W-1:0] LAST_SUB = SUB_W'(SUB_TICKS - 1);
   localparam logic [HALF_W-1:0] LAST_HALF = HALF_W'(BLINK_HALF_TICKS - 1);
   localparam logic [FS_W-1:0] FS_LAST = FS_W'(FS_LIMIT_CYCLES - 1);

   // Serial port state.
   logic sclk_q;
   logic cs_n_q;
   logic [15:0] shift;
   logic [4:0] bit_cnt;

   // Registers written by the controller.
   logic [7:0] decode_select;
   logic [7:0] duty_level;
   logic [7:0] config_reg;

   // Multiplex clock and fail-safe.
   logic pin_q;
   logic [FS_W-1:0] fs_cnt;
   // Cycles since the last tick or sync write, kept apart from the fail-safe counter so the checks below can judge it.
   logic [FS_W-1:0] gap_cnt;

   // Scan and blink dividers.
   logic [SUB_W-1:0] sub_cnt;
   logic [3:0] sub_idx;
   logic [DIGIT_W-1:0] digit;
   logic [HALF_W-1:0] half_cnt;
   logic fast_phase;
   logic slow_phase;

   // Output pipeline.
   logic lit_q;
   logic [7:0] decoded;

   wire sclk_rise;
   wire cs_rise;
   wire frame_ok;
   wire [7:0] wr_addr;
   wire [7:0] wr_data;
   wire wr_decode;
   wire wr_duty;
   wire wr_config;
   wire sync_req;
   wire pin_rise;
   wire fs_expire;
   wire mux_tick;
   wire sub_end;
   wire slot_end;
   wire half_end;
   wire [3:0] duty_code;
   wire [3:0] duty_step;
   wire seg_lit;
   wire [FS_W-1:0] next_fs_cnt;

   function automatic logic [NUM_DIGITS-1:0] digit_onehot(input logic [DIGIT_W-1:0] idx);
      digit_onehot = '0;
      digit_onehot[idx] = 1'b1;
   endfunction

   // Serial word decode; a write takes effect when select rises after 16 bits.
   assign sclk_rise = I_SCLK & ~sclk_q;
   assign cs_rise = I_CS_N & ~cs_n_q;
   assign frame_ok = cs_rise && (bit_cnt == FRAME_BITS);
   assign wr_addr = shift[ADDR_MSB:ADDR_LSB];
   assign wr_data = shift[DATA_MSB:DATA_LSB];
   assign wr_decode = frame_ok && (wr_addr == ADDR_DECODE_SELECT);
   assign wr_duty = frame_ok && (wr_addr == ADDR_DUTY_LEVEL);
   assign wr_config = frame_ok && (wr_addr == ADDR_CONFIG);
   assign sync_req = wr_config && wr_data[CFG_SYNC_BIT];

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
      begin
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         shift <= 16'h0000;
         bit_cnt <= 5'h00;
      end
      else
      begin
         sclk_q <= I_SCLK;
         cs_n_q <= I_CS_N;
         if (I_CS_N)
            bit_cnt <= 5'h00;
         else if (sclk_rise)
         begin
            shift <= {shift[14:0], I_DIN};
            if (bit_cnt != FRAME_BITS)
               bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
      begin
         decode_select <= DECODE_SELECT_RESET;
         duty_level <= DUTY_LEVEL_RESET;
         config_reg <= CONFIG_RESET;
      end
      else
      begin
         if (wr_decode)
            decode_select <= wr_data;
         if (wr_duty)
            duty_level <= wr_data;
         if (wr_config)
            config_reg <= wr_data;
      end
   end

   // Every multiplex tick comes from the pin or from the fail-safe, whatever drives the pin.
   assign pin_rise = I_MUX_CLOCK_PIN & ~pin_q;
   assign fs_expire = (fs_cnt == FS_LAST) && !pin_rise;
   assign mux_tick = pin_rise | fs_expire;
   assign next_fs_cnt = (mux_tick || sync_req) ? '0 : fs_cnt + FS_W'(1);

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
      begin
         pin_q <= 1'b0;
         fs_cnt <= '0;
         gap_cnt <= '0;
         O_FAILSAFE_ACTIVE <= 1'b0;
      end
      else
      begin
         pin_q <= I_MUX_CLOCK_PIN;
         fs_cnt <= next_fs_cnt;
         gap_cnt <= (mux_tick || sync_req) ? '0 : gap_cnt + FS_W'(1);
         if (fs_expire)
            O_FAILSAFE_ACTIVE <= 1'b1;
         else if (pin_rise)
            O_FAILSAFE_ACTIVE <= 1'b0;
      end
   end

   // Slot of 16 subintervals of SUB_TICKS ticks each.
   assign sub_end = mux_tick && (sub_cnt == LAST_SUB);
   assign slot_end = sub_end && (sub_idx == DUTY_STEPS_LAST);
   assign half_end = mux_tick && (half_cnt == LAST_HALF);

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET || sync_req)
      begin
         sub_cnt <= '0;
         sub_idx <= 4'h0;
         digit <= '0;
         half_cnt <= '0;
         fast_phase <= 1'b0;
         slow_phase <= 1'b0;
      end
      else
      begin
         if (mux_tick)
            sub_cnt <= sub_end ? '0 : sub_cnt + SUB_W'(1);
         if (sub_end)
            sub_idx <= sub_idx + 4'h1;
         if (slot_end)
            digit <= (digit == LAST_DIGIT) ? '0 : digit + DIGIT_W'(1);
         if (mux_tick)
            half_cnt <= half_end ? '0 : half_cnt + HALF_W'(1);
         if (half_end)
         begin
            fast_phase <= ~fast_phase;
            if (fast_phase)
               slow_phase <= ~slow_phase;
         end
      end
   end

   // Duty: code n lights n+1 of 16 subintervals, code 15 acts as 14.
   assign duty_code = duty_level[DUTY_MSB:0];
   assign duty_step = (duty_code == DUTY_TOP_CODE) ? DUTY_MAX_STEP : duty_code;
   assign seg_lit = (sub_idx <= duty_step);

   lmsid_hex_font u_font
   (
      .i_data(I_DIGIT_DATA),
      .i_decode(decode_select[O_SCAN_DIGIT]),
      .o_segments(decoded)
   );

   // Two stages: index to the digit store, then segments and digit enable together.
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
      begin
         O_SCAN_DIGIT <= '0;
         lit_q <= 1'b0;
         O_SEGMENT <= 8'h00;
         O_DIGIT_ENABLE <= '0;
         O_BLINK_PHASE <= 1'b0;
      end
      else
      begin
         O_SCAN_DIGIT <= digit;
         lit_q <= seg_lit;
         O_SEGMENT <= lit_q ? decoded : 8'h00;
         O_DIGIT_ENABLE <= digit_onehot(O_SCAN_DIGIT);
         O_BLINK_PHASE <= config_reg[CFG_BLINK_EN_BIT] &
                          (config_reg[CFG_RATE_BIT] ? fast_phase : slow_phase);
      end
   end

   default clocking chk_clk @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_RESET);

   chk_sync_clears_counters: assert property (
      sync_req |=> (digit == '0) && (sub_idx == 4'h0) && (half_cnt == '0) && !fast_phase && !slow_phase)
      else $error("Sync write did not clear the scan and blink counters.");

   chk_sync_on_select: assert property (
      (sub_cnt != $past(sub_cnt)) && (sub_cnt == '0) && ($past(sub_cnt) != LAST_SUB)
         |-> $past(cs_rise) && $past(wr_config))
      else $error("Counters cleared without a sync write ending on select.");

   chk_slot_length: assert property (
      (digit != $past(digit)) && !$past(sync_req) |-> $past(sub_idx) == DUTY_STEPS_LAST && $past(sub_end))
      else $error("Digit advanced before its slot of ticks ended.");

   chk_digit_wrap: assert property (
      slot_end && !sync_req && (digit == LAST_DIGIT) |=> digit == '0)
      else $error("Scan did not wrap to the first digit.");

   chk_failsafe_gap: assert property (
      gap_cnt <= FS_LAST)
      else $error("Multiplex clock stalled beyond the fail-safe limit.");

   chk_failsafe_flag: assert property (
      (gap_cnt == FS_LAST) && !pin_rise |=> O_FAILSAFE_ACTIVE)
      else $error("Fail-safe tick inserted without raising the flag.");

   chk_failsafe_insert: assert property (
      (fs_cnt == FS_LAST) && !sync_req |-> mux_tick ##1 (fs_cnt == '0))
      else $error("Fail-safe did not insert a tick.");

   chk_duty_blank: assert property (
      (sub_idx > duty_step) ##1 1'b1 |=> O_SEGMENT == 8'h00)
      else $error("Segments lit beyond the selected duty.");

   chk_decimal_point: assert property (
      lit_q && I_DIGIT_DATA[DP_BIT] |=> O_SEGMENT[DP_BIT])
      else $error("Decimal point not lit from bit 7.");

   chk_raw_segments: assert property (
      lit_q && !decode_select[O_SCAN_DIGIT] |=> O_SEGMENT == $past(I_DIGIT_DATA))
      else $error("Raw digit data did not reach the segments.");

   chk_font_lookup: assert property (
      lit_q && decode_select[O_SCAN_DIGIT] |=> O_SEGMENT[6:0] == LMSID_FONT[$past(I_DIGIT_DATA[3:0])])
      else $error("Decoded digit does not match the font.");

   chk_one_digit: assert property (
      $onehot(O_DIGIT_ENABLE) || ($past(I_RESET) && O_DIGIT_ENABLE == '0))
      else $error("Other than one digit enabled.");

   chk_duty_write: assert property (
      wr_duty |=> duty_level == $past(wr_data))
      else $error("Duty register did not take the written value.");

endmodule // lmsid_scan

// file: bench/lmsid_host_model.sv
// Host side: serial register writer and shared external multiplex clock source.
// Assumes the bench calls write_frame just after a core clock edge.
`timescale 1ns/1ps
module lmsid_host_model
   import lmsid_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_mux_run,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_din,
   output logic o_mux_pin
);
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b0;
      o_mux_pin = 1'b0;
   end

   // Time is scaled: the scan and blink counters count ticks only, so a steady tick every two core cycles stands for a rated clock.
   always @(posedge i_clk)
      o_mux_pin <= #1 i_mux_run ? ~o_mux_pin : 1'b0;

   // Sends the top nbits of word, MSB first; fewer than 16 makes a frame the design must refuse.
   task automatic write_frame(input logic [15:0] word, input int nbits);
      repeat (2) @(posedge i_clk);
      #1 o_cs_n = 1'b0;
      for (int i = 15; i > 15 - nbits; i--)
      begin
         o_din = word[i];
         o_sclk = 1'b0;
         repeat (2) @(posedge i_clk);
         #1 o_sclk = 1'b1;
         repeat (2) @(posedge i_clk);
         #1;
      end
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_din = ~o_din;
   endtask
endmodule // lmsid_host_model

// file: bench/test_led_mux_scan_intensity_decode.sv
// Self-checking bench for scan timing, duty, blink, fail-safe and digit decode.
// Assumes the host model drives the serial pins and the multiplex clock pin.
`timescale 1ns/1ps
module test_led_mux_scan_intensity_decode;
   import lmsid_pkg::*;
   typedef struct {logic [15:0] vis; int len; int steps;} lmsid_slot_t;
   localparam int TICK_CYC = 2;
   localparam int HALF = 20;
   localparam logic [6:0] FONT [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70,
      7'h7F, 7'h7B, 7'h77, 7'h1F, 7'h4E, 7'h3F, 7'h4F, 7'h47};
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic mux_run = 1'b1;
   wire logic cs_n, sclk, din, mux_pin;
   logic [7:0] digit_data;
   logic [2:0] scan_digit;
   logic [7:0] digit_en, segment, last_en;
   logic blink_phase, failsafe, last_phase;
   logic [7:0] mem [8];
   lmsid_slot_t slot_q [$];
   lmsid_slot_t slot;
   int blink_q [$];
   int miscompares = 0;
   int checks_done = 0;
   int slot_len, lit, blink_len;
   logic armed = 1'b0, blink_arm = 1'b0, open = 1'b0, blink_open = 1'b0;
   logic [15:0] first_vis;

   always #2.5 core_clk = ~core_clk;
   assign digit_data = mem[scan_digit];

   lmsid_host_model u_host (.i_clk(core_clk), .i_mux_run(mux_run), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_din(din), .o_mux_pin(mux_pin));
   lmsid_scan #(.NUM_DIGITS(8), .BLINK_HALF_TICKS(HALF)) u_lmsid_scan (.I_CORE_CLK(core_clk),
      .I_RESET(reset), .I_CS_N(cs_n), .I_SCLK(sclk), .I_DIN(din), .I_MUX_CLOCK_PIN(mux_pin),
      .I_DIGIT_DATA(digit_data), .O_SCAN_DIGIT(scan_digit), .O_DIGIT_ENABLE(digit_en),
      .O_SEGMENT(segment), .O_BLINK_PHASE(blink_phase), .O_FAILSAFE_ACTIVE(failsafe));

   function automatic logic [7:0] exp_seg(input logic [7:0] data, input logic dec);
      return dec ? {data[7], FONT[data[3:0]]} : data;
   endfunction

   task automatic check_vis(input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t enable/segment exp %h got %h", $time, exp, got);
      end
   endtask

   task automatic check_num(input int exp, input int got);
      checks_done++;
      if (got != exp)
      begin
         miscompares++;
         $display("MISMATCH %0t count exp %0d got %0d", $time, exp, got);
      end
   endtask

   task automatic complete_run;
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // A slot is judged when the next one starts: first enable/segment pair, length and lit subintervals.
   always @(posedge core_clk)
   begin
      if (!armed)
         open = 1'b0;
      else if (digit_en !== last_en)
      begin
         if (open && slot_q.size() > 0)
         begin
            slot = slot_q.pop_front();
            check_vis(slot.vis, first_vis);
            check_num(slot.len, slot_len);
            check_num(slot.steps, (lit + 50) / 100);
         end
         open = 1'b1;
         first_vis = {digit_en, segment};
         slot_len = 0;
         lit = 0;
      end
      slot_len++;
      if (segment !== 8'h00)
         lit++;
      last_en = digit_en;
      if (!blink_arm)
         blink_open = 1'b0;
      else if (blink_phase !== last_phase)
      begin
         if (blink_open && blink_q.size() > 0)
            check_num(blink_q.pop_front(), blink_len);
         blink_open = 1'b1;
         blink_len = 0;
      end
      blink_len++;
      last_phase = blink_phase;
   end

   initial
   begin
      logic [7:0] duty, dec;
      int seed, cnt;
      for (int d = 0; d < 8; d++)
         mem[d] = 8'h00;
      seed = $urandom(80);
      repeat (2) @(posedge core_clk);
      #1 reset = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         duty = $urandom;
         dec = $urandom;
         if (k == 0)
            duty[3:0] = 4'hF;
         if (k == 1)
            duty[3:0] = 4'h0;
         if (k == 2)
            duty[3:0] = 4'hE;
         if (k != 3)
            dec = (k == 1) ? 8'h00 : 8'hFF;
         for (int d = 0; d < 8; d++)
         begin
            mem[d] = $urandom;
            if (k == 0 || k == 2)
               mem[d][3:0] = 4'(d + 4 * k);
            if (!dec[d])
               mem[d][0] = 1'b1;
            slot_q.push_back('{{8'h01 << d, exp_seg(mem[d], dec[d])}, 800 * TICK_CYC,
               (duty[3:0] == 4'hF) ? 15 : duty[3:0] + 1});
         end
         u_host.write_frame({ADDR_DECODE_SELECT, dec}, 16);
         u_host.write_frame({ADDR_DUTY_LEVEL, duty}, 16);
         u_host.write_frame({ADDR_DUTY_LEVEL, ~duty}, 12);
         // Restart away from the wrap so that the new digit zero is always a visible change.
         for (cnt = 0; cnt < 4000 && (scan_digit === 3'h0 || scan_digit === 3'h7); cnt++)
            @(posedge core_clk);
         u_host.write_frame({ADDR_CONFIG, 8'h10}, 16);
         // A tick on the clearing edge is lost and the slot keeps its length; otherwise it is one cycle short.
         #1 slot_q[0].len = mux_pin ? 800 * TICK_CYC : 800 * TICK_CYC - 1;
         repeat (3) @(posedge core_clk);
         #1 armed = 1'b1;
         for (cnt = 0; cnt < 20000 && slot_q.size() > 0; cnt++)
            @(posedge core_clk);
         #1 armed = 1'b0;
         check_num(0, slot_q.size());
      end
      for (int r = 0; r < 2; r++)
      begin
         u_host.write_frame({ADDR_CONFIG, (r == 0) ? 8'h0C : 8'h08}, 16);
         blink_q.push_back(HALF * TICK_CYC * (r + 1));
         blink_q.push_back(HALF * TICK_CYC * (r + 1));
         repeat (3) @(posedge core_clk);
         #1 blink_arm = 1'b1;
         for (cnt = 0; cnt < 1000 && blink_q.size() > 0; cnt++)
            @(posedge core_clk);
         #1 blink_arm = 1'b0;
         check_num(0, blink_q.size());
      end
      mux_run = 1'b0;
      for (cnt = 0; cnt < 4000 && failsafe !== 1'b1; cnt++)
      begin
         @(posedge core_clk);
         #1;
      end
      check_num(1, int'(cnt >= 2640 && cnt <= 2660));
      mux_run = 1'b1;
      for (cnt = 0; cnt < 20 && failsafe !== 1'b0; cnt++)
      begin
         @(posedge core_clk);
         #1;
      end
      check_num(1, int'(cnt < 20));
      complete_run();
   end

   initial
   begin
      #450000;
      miscompares++;
      complete_run();
   end
endmodule // test_led_mux_scan_intensity_decode
